// ### hdl/adc_mode_and_rate_control.sv
// Mode, output-rate, ready and continuous-readout control of the converter
// How it works
// RULE1: 60 Hz notch added at 50 Hz
// RULE2: Chop off: rate is MCLK/1024/code
// RULE3: Chop on: rate divided by sinc order; here only with fast settling off
// RULE4: Plain filter: first notch equals rate
// RULE5: Chop notches at odd half-rate multiples
// RULE6: Mode zero converts continuously, default
// RULE7: Conversion done drives ready low
// RULE8: Continuous read shifts results on clock
// RULE9: Host may read via command instead
// RULE10: First result only after full settling
// RULE11: Single mode: wake 200 us, convert
// RULE12: Single result stored, then power down
// RULE13: Ready held until read or reconversion
// RULE14: Idle resets filter, clocks keep running
// RULE15: Power-down stops all, crystal runs
// RULE16: Fast settling ignores single-cycle without chop
// RULE17: Single-cycle settles in one conversion
// RULE18: New setting aborts and restarts settling
`include "adc_ctrl_params.svh"
`default_nettype none
module adc_mode_and_rate_control
    import adc_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    // Master clock enable, one pulse per modulator clock
    input wire logic mclk_tick,
    input wire logic op_mode_sel_bit2,
    input wire logic op_mode_sel_bit1,
    input wire logic op_mode_sel_bit0,
    input wire logic [9:0] rate_select_code,
    input wire logic chop_enable,
    input wire logic fast_settle_enable,
    input wire logic single_cycle_enable,
    input wire logic notch60_enable,
    input wire logic multi_channel,
    input wire logic [2:0] sinc_order,
    input wire logic continuous_read_enable,
    // One-cycle pulse: setting written by host
    input wire logic cfg_write,
    // One-cycle pulse: host read command completed
    input wire logic data_read,
    input wire logic [23:0] conv_sample,
    // Serial clock edge from host, one-cycle pulse
    input wire logic sclk_edge,
    output logic dout_rdy_n,
    output logic status_rdy_n,
    output logic [23:0] data_reg,
    output logic filter_reset,
    output logic modulator_clk_en,
    output logic analog_power_en,
    output logic notch60_active,
    output logic chop_notches_active,
    output logic rate_tick,
    output logic fifo_overflow
);
    op_mode_t mode;
    conv_state_t state_reg;
    logic [2:0] mode_prev_reg;
    logic [9:0] code_eff;
    logic [12:0] settle_div;
    logic [2:0] order_eff;
    logic [2:0] settle_need;
    logic [2:0] settle_cnt_reg;
    logic [15:0] wake_cnt_reg;
    logic restart;
    logic pre_tick;
    logic code_tick;
    logic conv_tick;
    logic conv_done;
    logic div_run;
    logic single_cyc_eff;
    logic fifo_in_ready;
    logic [23:0] fifo_data;
    logic fifo_valid;
    logic fifo_pop;
    logic [23:0] shift_reg;
    logic [4:0] bits_left_reg;
    logic sample_done_reg;

    // Codes 1xx fall to the default branches and behave as power-down
    assign mode = op_mode_t'({op_mode_sel_bit2, op_mode_sel_bit1, op_mode_sel_bit0});
    // RULE2 valid code range
    assign code_eff = (rate_select_code < `RATE_MIN) ? `RATE_MIN : rate_select_code;
    // Order zero is no filter at all, so it falls back to the default order
    assign order_eff = (sinc_order == 3'h0) ? `SINC_ORDER_DEF : sinc_order;
    // RULE16 single-cycle gated by chop
    assign single_cyc_eff = single_cycle_enable && !multi_channel && (mode != MODE_SINGLE)
        && (!fast_settle_enable || chop_enable);
    // RULE17 one-cycle settling
    // Settling is counted in whole periods of the last divider
    assign settle_need = single_cyc_eff ? 3'h1 : (chop_enable ? 3'h2 : order_eff);
    assign settle_div = chop_enable && !fast_settle_enable ? {10'h000, order_eff} : 13'h0001;
    // RULE18 abort on reconfiguration
    // Comparing with last cycle's mode also catches a change without a write strobe
    assign restart = cfg_write || (mode_prev_reg != mode);
    // RULE11 dividers wait out the wake time
    // Holding them here keeps settling from starting before the clock is stable
    assign div_run = mclk_tick && modulator_clk_en && !filter_reset && (state_reg != ST_WAKE);

    // RULE2 MCLK divided by 1024
    rate_divider #(.W(11)) u_pre (
        .clk(clk),
        .sys_rst(sys_rst),
        .restart(restart),
        .tick_in(div_run),
        .divisor(`MCLK_PRE_DIV),
        .tick_out(pre_tick)
    );
    // RULE2 divided again by code
    rate_divider #(.W(10)) u_code (
        .clk(clk),
        .sys_rst(sys_rst),
        .restart(restart),
        .tick_in(pre_tick),
        .divisor(code_eff),
        .tick_out(code_tick)
    );
    // RULE3 chop without fast settling divides by order
    rate_divider #(.W(13)) u_chop (
        .clk(clk),
        .sys_rst(sys_rst),
        .restart(restart),
        .tick_in(code_tick),
        .divisor(settle_div),
        .tick_out(conv_tick)
    );

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_prev_reg <= `MODE_RESET;
        end else begin
            mode_prev_reg <= mode;
        end
    end

    // RULE6 RULE11 RULE14 RULE15 mode sequencing
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= ST_SETTLE;
            wake_cnt_reg <= '0;
            settle_cnt_reg <= '0;
        end else if (restart) begin
            settle_cnt_reg <= '0;
            wake_cnt_reg <= '0;
            case (mode)
                MODE_CONT: state_reg <= ST_SETTLE;
                MODE_SINGLE: state_reg <= ST_WAKE;
                default: state_reg <= ST_OFF;
            endcase
        end else begin
            case (state_reg)
                ST_WAKE: begin
                    // RULE11 internal clock wake time
                    // Counted in system clocks, so it does not depend on the master clock rate
                    if (wake_cnt_reg == 16'(`CLK_SETTLE_CYC - 1)) begin
                        state_reg <= ST_SETTLE;
                    end else begin
                        wake_cnt_reg <= wake_cnt_reg + 16'h0001;
                    end
                end
                ST_SETTLE: begin
                    // RULE10 full settling first
                    if (conv_tick) begin
                        if (settle_cnt_reg + 3'h1 >= settle_need) begin
                            state_reg <= (mode == MODE_SINGLE) ? ST_OFF : ST_RUN;
                        end else begin
                            settle_cnt_reg <= settle_cnt_reg + 3'h1;
                        end
                    end
                end
                ST_RUN: begin
                    state_reg <= ST_RUN;
                end
                ST_OFF: begin
                    // Only a restart leaves the off state
                    state_reg <= ST_OFF;
                end
                default: state_reg <= ST_OFF;
            endcase
        end
    end

    // RULE6 RULE10 RULE12 result after settling, then each rate tick
    // Gating with restart drops a result from a setting that is being replaced
    assign conv_done = !restart && conv_tick &&
        ((state_reg == ST_RUN) ||
         (state_reg == ST_SETTLE && settle_cnt_reg + 3'h1 >= settle_need));

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            data_reg <= '0;
            sample_done_reg <= 1'b0;
        end else begin
            sample_done_reg <= conv_done;
            // RULE12 result held until overwritten
            // Nothing but a completed conversion writes it
            if (conv_done) begin
                data_reg <= conv_sample;
            end
        end
    end

    // RULE7 RULE13 ready low on completion, high on read or new setting
    // Set beats clear, so a result landing with a read is never lost
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            status_rdy_n <= 1'b1;
        end else if (conv_done) begin
            status_rdy_n <= 1'b0;
        end else if (data_read || restart) begin
            status_rdy_n <= 1'b1;
        end
    end

    // RULE14 RULE15 power and clock controls
    // Idle keeps the analog side powered; only power-down and the off state cut it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            filter_reset <= 1'b0;
            modulator_clk_en <= 1'b1;
            analog_power_en <= 1'b1;
        end else begin
            filter_reset <= (mode == MODE_IDLE) || (state_reg == ST_OFF);
            modulator_clk_en <= (mode == MODE_IDLE) || (state_reg != ST_OFF);
            analog_power_en <= (state_reg != ST_OFF) || (mode == MODE_IDLE);
        end
    end

    // RULE1 RULE4 RULE5 notch status
    // Notch positions follow the rate; only the enables are reported here
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            notch60_active <= 1'b0;
            chop_notches_active <= 1'b0;
            rate_tick <= 1'b0;
        end else begin
            notch60_active <= notch60_enable;
            chop_notches_active <= chop_enable;
            rate_tick <= conv_done;
        end
    end

    // Leaving continuous read flushes queued words so stale results never shift out
    result_fifo #(.WIDTH(`DATA_W), .DEPTH(`FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .flush(restart || !continuous_read_enable),
        .in_data(data_reg),
        .in_valid(sample_done_reg && continuous_read_enable),
        .in_ready(fifo_in_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fifo_overflow <= 1'b0;
        end else if (sample_done_reg && continuous_read_enable && !fifo_in_ready) begin
            // Sticky until the next restart, so the host learns words were dropped
            fifo_overflow <= 1'b1;
        end else if (restart) begin
            fifo_overflow <= 1'b0;
        end
    end

    // RULE8 continuous readout shifter
    // A word is loaded only once the last one is fully out, so no bit is skipped
    assign fifo_pop = fifo_valid && (bits_left_reg == 5'h00) && continuous_read_enable;
    always_ff @(posedge clk) begin
        if (sys_rst || !continuous_read_enable) begin
            shift_reg <= '0;
            bits_left_reg <= '0;
        end else if (fifo_pop) begin
            shift_reg <= fifo_data;
            bits_left_reg <= 5'h18;
        end else if (sclk_edge && bits_left_reg != 5'h00) begin
            shift_reg <= {shift_reg[22:0], 1'h0};
            bits_left_reg <= bits_left_reg - 5'h01;
        end
    end

    // RULE7 RULE8 shared pin: data while shifting, otherwise ready
    // Continuous read owns the pin; outside it the pin mirrors the ready flag
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dout_rdy_n <= 1'b1;
        end else if (continuous_read_enable && bits_left_reg != 5'h00) begin
            dout_rdy_n <= shift_reg[23];
        end else if (continuous_read_enable) begin
            dout_rdy_n <= !fifo_valid;
        end else if (conv_done) begin
            dout_rdy_n <= 1'b0;
        end else if (data_read || restart) begin
            dout_rdy_n <= 1'b1;
        end
    end
endmodule // adc_mode_and_rate_control
`default_nettype wire

// ### hdl/adc_ctrl_params.svh
// Constants for the converter mode and rate control block
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH
`define MCLK_PRE_DIV 11'h400
`define RATE_MIN 10'h001
`define RATE_MAX 10'h3FF
`define SINC_ORDER_DEF 3'h4
`define MODE_RESET 3'h0
`define CLK_HZ 20000000
`define CLK_SETTLE_US 200
`define CLK_SETTLE_CYC ((`CLK_SETTLE_US * (`CLK_HZ / 1000000)))
`define FIFO_DEPTH 16
`define DATA_W 24
`define NOTCH_BASE_50HZ 50
`define NOTCH_EXTRA_60HZ 60
`define CHOP_NOTCH_DEN 2
`endif

// ### hdl/adc_ctrl_pkg.sv
// Types shared by the converter mode and rate control block
`default_nettype none
package adc_ctrl_pkg;
    typedef enum logic [2:0] {
        MODE_CONT = 3'h0,
        MODE_SINGLE = 3'h1,
        MODE_IDLE = 3'h2,
        MODE_PDOWN = 3'h3
    } op_mode_t;
    typedef enum {
        ST_OFF,
        ST_WAKE,
        ST_SETTLE,
        ST_RUN
    } conv_state_t;
endpackage
`default_nettype wire

// ### hdl/result_fifo.sv
// Result FIFO with valid/ready on both sides
`default_nettype none
module result_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic flush,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;
    assign in_ready = (cnt_reg != DEPTH[AW:0]);
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem_reg[rd_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst || flush) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= rd_reg + 1'b1;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
endmodule // result_fifo
`default_nettype wire

// ### hdl/rate_divider.sv
// Programmable divider producing one-cycle enable pulses
`default_nettype none
module rate_divider #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic restart,
    input wire logic tick_in,
    input wire logic [W-1:0] divisor,
    output logic tick_out
);
    logic [W-1:0] cnt_reg;
    always_ff @(posedge clk) begin
        if (sys_rst || restart) begin
            cnt_reg <= '0;
            tick_out <= 1'b0;
        end else if (tick_in) begin
            if (cnt_reg + 1'b1 >= divisor) begin
                cnt_reg <= '0;
                tick_out <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
                tick_out <= 1'b0;
            end
        end else begin
            tick_out <= 1'b0;
        end
    end
endmodule // rate_divider
`default_nettype wire

// ### dv/adc_mode_and_rate_control_properties.sv
// Concurrent checks on the mode and rate control ports
`default_nettype none
module adc_mode_and_rate_control_properties (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic op_mode_sel_bit2,
    input wire logic op_mode_sel_bit1,
    input wire logic op_mode_sel_bit0,
    input wire logic notch60_enable,
    input wire logic cfg_write,
    input wire logic data_read,
    input wire logic dout_rdy_n,
    input wire logic status_rdy_n,
    input wire logic [23:0] data_reg,
    input wire logic filter_reset,
    input wire logic modulator_clk_en,
    input wire logic analog_power_en,
    input wire logic notch60_active,
    input wire logic rate_tick
);
    timeunit 1ns;
    timeprecision 1ns;
    wire [2:0] md = {op_mode_sel_bit2, op_mode_sel_bit1, op_mode_sel_bit0};
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // A setting write may legally raise ready again, so it is kept out of the window
    sequence s_result;
        rate_tick && !cfg_write && !data_read ##1 (!cfg_write && !data_read) [*2];
    endsequence
    // A result in the read's own cycle wins, so that case is left out
    sequence s_quiet_read;
        data_read && !cfg_write ##1 !rate_tick;
    endsequence
    a_reset_values: assert property (disable iff (1'h0)
        sys_rst |=> status_rdy_n && dout_rdy_n && data_reg == 24'h0 && analog_power_en)
        else $error("outputs wrong after reset");
    a_idle_holds_reset: assert property ((md == 3'h2) [*3] |-> filter_reset && modulator_clk_en)
        else $error("idle without filter reset or modulator clock");
    a_pdown_power_off: assert property ((md == 3'h3) [*3] |-> !analog_power_en)
        else $error("power-down left analog powered");
    a_notch_copy: assert property ((notch60_enable) [*2] |-> notch60_active)
        else $error("extra notch not active");
    a_result_ready: assert property (s_result |-> !status_rdy_n)
        else $error("ready not low after result");
    a_ready_held: assert property (
        !status_rdy_n && !data_read && !cfg_write && $stable(md) |=> !status_rdy_n)
        else $error("ready dropped without read");
    a_read_clears: assert property (s_quiet_read |-> status_rdy_n)
        else $error("ready still low after read");
    a_data_on_result: assert property (
        !$stable(data_reg) |-> rate_tick || $past(rate_tick) || $past(rate_tick, 2))
        else $error("data changed without result");
endmodule // adc_mode_and_rate_control_properties
bind adc_mode_and_rate_control adc_mode_and_rate_control_properties props_inst (.*);
`default_nettype wire

// ### dv/host_model.sv
// Host model: takes each result by command or by continuous shifting
`default_nettype none
module host_model (
    input wire logic clk,
    input wire logic status_rdy_n,
    input wire logic dout_rdy_n,
    input wire logic continuous_read_enable,
    input wire logic stall,
    output logic sclk_edge,
    output logic data_read,
    output logic [23:0] word,
    output logic got
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sclk_edge = 1'h0;
        data_read = 1'h0;
        word = 24'h0;
        got = 1'h0;
        forever begin
            @(posedge clk);
            got <= 1'h0;
            if (status_rdy_n === 1'h0 && !stall) begin
                // Reaction time keeps the read clear of the edge that set ready
                repeat (4) @(posedge clk);
                for (int i = 0; i < 24 && continuous_read_enable; i++) begin
                    word = {word[22:0], dout_rdy_n};
                    sclk_edge <= 1'h1;
                    @(posedge clk);
                    sclk_edge <= 1'h0;
                    @(posedge clk);
                    // The pin is registered, so the new bit shows one clock after the shift
                    @(posedge clk);
                end
                data_read <= 1'h1;
                @(posedge clk);
                data_read <= 1'h0;
                got <= continuous_read_enable;
            end
        end
    end
endmodule // host_model
`default_nettype wire

// ### dv/adc_mode_and_rate_control_bench.sv
// Self-checking bench for the mode and rate control block
`include "adc_ctrl_params.svh"
`default_nettype none
module adc_mode_and_rate_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, sys_rst = 1, mclk_tick = 1, cfg_write = 0, stall = 0, chk_words = 0;
    logic op_mode_sel_bit2 = 0, op_mode_sel_bit1 = 0, op_mode_sel_bit0 = 0;
    logic chop_enable = 0, fast_settle_enable = 0, single_cycle_enable = 0;
    logic notch60_enable = 0, multi_channel = 0, continuous_read_enable = 0;
    logic [9:0] rate_select_code = 10'h001, c;
    logic [2:0] sinc_order = 3'h2;
    logic [23:0] conv_sample = 24'h0, last_smp = 24'h0, data_reg, word;
    logic dout_rdy_n, status_rdy_n, filter_reset, modulator_clk_en, analog_power_en;
    logic notch60_active, chop_notches_active, rate_tick, fifo_overflow;
    logic data_read, sclk_edge, got;
    int n_errors = 0, checked = 0, n_tick = 0, n0;
    adc_mode_and_rate_control adc_mode_and_rate_control_inst (.*);
    host_model host_model_inst (.*);
    task automatic check(input bit ok, input string msg);
        checked++;
        if (!ok) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Chop without fast settling divides the rate by the filter order
    function automatic int period(input logic [9:0] cd, input logic [3:0] f);
        return 1024 * int'(cd) * ((f[3] && !f[2]) ? int'(sinc_order) : 1);
    endfunction
    // Single-cycle needs one channel, and chop once fast settling is on
    function automatic int settle(input logic [3:0] f);
        return (f[1] && !f[0] && (f[3] || !f[2])) ? 1 : (f[3] ? 2 : int'(sinc_order));
    endfunction
    task automatic pulse_cfg;
        cfg_write <= 1'h1;
        @(posedge clk);
        cfg_write <= 1'h0;
    endtask
    task automatic wait_tick(inout int t);
        while (rate_tick !== 1'h1 && t < 40000) begin
            @(posedge clk);
            t++;
        end
    endtask
    task automatic run(input logic [2:0] m, input logic [9:0] cd, input logic [3:0] f);
        int per, lat, t;
        per = period(cd, f);
        lat = (m == 3'h1 ? `CLK_SETTLE_CYC : 0) + settle(f) * per;
        {op_mode_sel_bit2, op_mode_sel_bit1, op_mode_sel_bit0} <= m;
        rate_select_code <= cd;
        {chop_enable, fast_settle_enable, single_cycle_enable, multi_channel} <= f;
        notch60_enable <= 1'($urandom);
        pulse_cfg();
        t = 0;
        wait_tick(t);
        check(t >= lat - 4 && t <= lat + 8, "first result time");
        repeat (3) @(posedge clk);
        check(data_reg === last_smp, "result stored");
        check(status_rdy_n === 1'h0 && (continuous_read_enable || dout_rdy_n === 1'h0), "ready low");
        check(notch60_active === notch60_enable, "notch");
        check(chop_notches_active === chop_enable, "chop notches");
        t = 3;
        if (m == 3'h0) begin
            wait_tick(t);
            check(t == per, "result period");
        end else begin
            repeat (20) @(posedge clk);
            check(analog_power_en === 1'h0 && status_rdy_n === 1'h0, "single done");
        end
        $display("test done: mode %0d code %0d flags %b", m, cd, f);
    endtask
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    // About 80k cycles of tests; the limit trips only on a hang and stays under 100k
    initial begin
        #4900000;
        n_errors++;
        test_done();
    end
    always @(posedge clk) begin
        if (rate_tick === 1'h1) begin
            n_tick <= n_tick + 1;
            last_smp <= conv_sample;
            conv_sample <= 24'($urandom);
        end
        if (got === 1'h1 && chk_words) check(word === last_smp, "shifted word");
    end
    initial begin
        void'($urandom(32'h54F17135));
        repeat (2) @(posedge clk);
        sys_rst <= 1'h0;
        @(posedge clk);
        c = 10'(1 + $urandom % 2);
        run(3'h0, c, 4'h0);
        run(3'h0, c, 4'h8);
        run(3'h0, c, 4'h2);
        run(3'h0, c, 4'h3);
        run(3'h0, c, 4'h6);
        run(3'h0, c, 4'hE);
        stall <= 1'h1;
        run(3'h1, c, 4'h0);
        stall <= 1'h0;
        repeat (20) @(posedge clk);
        check(status_rdy_n === 1'h1, "ready after read");
        for (int m = 2; m < 4; m++) begin
            n0 = n_tick;
            {op_mode_sel_bit2, op_mode_sel_bit1, op_mode_sel_bit0} <= 3'(m);
            pulse_cfg();
            repeat (3000) @(posedge clk);
            check(n_tick == n0 && analog_power_en === (m == 2), "quiet mode");
            check(m == 3 || (filter_reset === 1'h1 && modulator_clk_en === 1'h1), "idle");
            $display("test done: quiet mode %0d", m);
        end
        continuous_read_enable <= 1'h1;
        chk_words <= 1'h1;
        run(3'h0, 10'h001, 4'h0);
        repeat (3000) @(posedge clk);
        chk_words <= 1'h0;
        stall <= 1'h1;
        repeat (10240) @(posedge clk);
        check(fifo_overflow === 1'h0, "early overflow");
        repeat (10240) @(posedge clk);
        check(fifo_overflow === 1'h1, "overflow");
        stall <= 1'h0;
        pulse_cfg();
        repeat (5) @(posedge clk);
        check(fifo_overflow === 1'h0, "overflow cleared");
        $display("test done: overflow");
        test_done();
    end
endmodule // adc_mode_and_rate_control_bench
`default_nettype wire
